// ===== verification/pll_and_power_mode_control_tb.sv
// self-checking bench for the pll and power mode controller
// assumes the wake source model and the port checker
`timescale 1ns/10ps
`default_nettype none
module pll_and_power_mode_control_tb;
  import pmc_pkg::*;
  logic REF_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [3:0] WSTRB = 4'hf;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, EXT_IRQ, WAKE_PIN;
  logic [1:0] BRESP, RRESP, rsp;
  logic [20:0] PLL_REF_DIVIDER;
  logic [38:0] PLL_FEEDBACK_FACTOR;
  logic [11:0] PLL_POST_VCO_DIVIDER;
  logic [2:0] PLL_BYPASS, PLL_POWER_DOWN;
  logic RTC_ALARM, SYS_CLK_PLL_SEL, SYS_CLK_OSC_SEL, CPU_CLK_EN;
  logic [26:0] UNIT_CLK_EN;
  logic CTRL_IRQ, SUPPLY_WAKE, lag;
  logic pol = 1'b0, slow = 1'b0;
  logic pin_req = 1'b0, rtc_req = 1'b0, irq_req = 1'b0;
  logic [31:0] rdv;
  int mismatches = 0, num_checks = 0;
  always #5 REF_CLK = ~REF_CLK;
  pll_and_power_mode_control dut (.REF_CLK, .SYS_RST, .AWADDR, .AWVALID,
    .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
    .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .EXT_IRQ,
    .WAKE_PIN, .RTC_ALARM, .PLL_REF_DIVIDER, .PLL_FEEDBACK_FACTOR,
    .PLL_POST_VCO_DIVIDER, .PLL_BYPASS, .PLL_POWER_DOWN, .SYS_CLK_PLL_SEL,
    .SYS_CLK_OSC_SEL, .CPU_CLK_EN, .UNIT_CLK_EN, .CTRL_IRQ, .SUPPLY_WAKE);
  wake_source partner (.clk(REF_CLK), .pol, .slow, .pin_req, .rtc_req,
    .irq_req, .wake_pin(WAKE_PIN), .rtc_alarm(RTC_ALARM), .ext_irq(EXT_IRQ));
  // ----------------------------------------
  // checks, bus tasks, expectations
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [12:0] plus_one(input logic [11:0] v);
    return {1'b0, v} + 13'h1;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic pa, pw;
    @(posedge REF_CLK);
    lag = 1'($urandom % 2);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= !lag;
    pa = 1'b1;
    pw = 1'b1;
    for (n = 0; (pa || pw || BVALID !== 1'b1) && n < 64; n++) begin
      @(posedge REF_CLK);
      if (pa && AWREADY) begin
        pa = 1'b0;
        AWVALID <= 1'b0;
      end
      if (pw && WREADY) begin
        pw = 1'b0;
        WVALID <= 1'b0;
      end
    end
    if (n == 64) mismatches++;
    if (lag) begin
      BREADY <= 1'b1;
      @(posedge REF_CLK);
    end
    rsp = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic pa;
    @(posedge REF_CLK);
    lag = 1'($urandom % 2);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= !lag;
    pa = 1'b1;
    for (n = 0; (pa || RVALID !== 1'b1) && n < 64; n++) begin
      @(posedge REF_CLK);
      if (pa && ARREADY) begin
        pa = 1'b0;
        ARVALID <= 1'b0;
      end
    end
    if (n == 64) mismatches++;
    if (lag) begin
      RREADY <= 1'b1;
      @(posedge REF_CLK);
    end
    rdv = RDATA;
    rsp = RRESP;
    RREADY <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdv, exp);
  endtask
  task automatic wait_cpu;
    for (int n = 0; n < 80 && CPU_CLK_EN !== 1'b1; n++) @(posedge REF_CLK);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    wrap_up;
  end
  initial begin
    logic [5:0] rf;
    logic [11:0] fb;
    logic [2:0] od;
    logic [26:0] g;
    logic [7:0] a;
    void'($urandom(85434));
    repeat (20) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    rchk(OFF_PWRCTL, 32'h0bb80000);
    rd(8'h40);
    chk(rsp, RESP_DECERR);
    chk(rdv, 32'h0);
    wr(8'h40, 32'hffffffff);
    chk(rsp, RESP_DECERR);
    wr(OFF_PWRCTL, 32'h00040000);
    wr(OFF_DIVCON, {30'h0, CLKSRC_OSC});
    for (int i = 0; i < 6; i++) begin
      a = OFF_PLLCON0 + 8'(4 * (i % 3));
      rf = (i == 0) ? 6'h3f : (i == 1) ? 6'h00 : 6'($urandom);
      fb = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 :
           12'((rf + 1) * (5 + $urandom % 21) - 1);
      od = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($urandom);
      wr(a, {10'h0, i[0], od, fb, rf});
      repeat (2) @(posedge REF_CLK);
      chk(PLL_REF_DIVIDER[(i % 3) * 7 +: 7], plus_one(rf));
      chk(PLL_FEEDBACK_FACTOR[(i % 3) * 13 +: 13], plus_one(fb));
      chk(PLL_POST_VCO_DIVIDER[(i % 3) * 4 +: 4], plus_one(od));
      chk(PLL_BYPASS[i % 3], i[0]);
      rchk(a, {10'h0, i[0], od, fb, rf});
    end
    repeat (10) @(posedge REF_CLK);
    rchk(OFF_STATUS, 32'h1f);
    wr(OFF_DIVCON, 32'h0);
    repeat (8) @(posedge REF_CLK);
    chk({SYS_CLK_PLL_SEL, SYS_CLK_OSC_SEL}, 2'b10);
    wr(OFF_PLLCON1, 32'h00400000);
    repeat (2) @(posedge REF_CLK);
    chk(PLL_POWER_DOWN, 3'b010);
    rchk(OFF_STATUS, 32'h1d);
    wr(OFF_PLLCON1, 32'h0);
    repeat (10) @(posedge REF_CLK);
    rchk(OFF_STATUS, 32'h1f);
    wr(OFF_DIVCON, {30'h0, CLKSRC_OSC});
    repeat (8) @(posedge REF_CLK);
    chk({SYS_CLK_PLL_SEL, SYS_CLK_OSC_SEL}, 2'b01);
    wr(OFF_DIVCON, 32'h0);
    repeat (8) @(posedge REF_CLK);
    chk({SYS_CLK_PLL_SEL, SYS_CLK_OSC_SEL}, 2'b10);
    g = 27'($urandom);
    wr(OFF_CLKCFG, {5'h0, g});
    repeat (2) @(posedge REF_CLK);
    chk(UNIT_CLK_EN, {5'h0, ~g});
    wr(OFF_CPUPD, CPUPD_MAGIC);
    chk(CPU_CLK_EN, 1'b0);
    chk(UNIT_CLK_EN, {5'h0, ~g});
    irq_req <= 1'b1;
    wait_cpu;
    chk(CPU_CLK_EN, 1'b1);
    irq_req <= 1'b0;
    for (int c = 0; c < 3; c++) begin
      wr(OFF_PWRCTL, {25'h000800, c == 1, 1'b0, c == 2, 1'b0, MODE_STOP});
      pol <= (c == 1);
      slow <= (c == 1);
      wr(OFF_CLKCFG, 32'h07fffffb);
      wr(OFF_CPUPD, CPUPD_MAGIC);
      repeat (2) @(posedge REF_CLK);
      chk(UNIT_CLK_EN, 32'h0);
      chk(PLL_POWER_DOWN, 3'b111);
      pin_req <= 1'b1;
      if (c == 2) begin
        repeat (20) @(posedge REF_CLK);
        chk(CPU_CLK_EN, 1'b0);
        rtc_req <= 1'b1;
      end
      wait_cpu;
      chk(CPU_CLK_EN, 1'b1);
      chk(UNIT_CLK_EN, 32'h4);
      chk(PLL_POWER_DOWN, 3'b000);
      chk(CTRL_IRQ, c != 2);
      chk(SUPPLY_WAKE, c == 2);
      rchk(OFF_STATUS, 32'h1f);
      pin_req <= 1'b0;
      rtc_req <= 1'b0;
      repeat (6) @(posedge REF_CLK);
      wr(OFF_PWRCTL, {25'h000800, c == 1, 1'b0, c == 2, 4'h8});
      repeat (3) @(posedge REF_CLK);
      chk(CTRL_IRQ, 1'b0);
    end
    wrap_up;
  end
endmodule
bind pll_and_power_mode_control pmc_assertions chk_i (.REF_CLK, .SYS_RST,
  .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY, .BRESP, .ARVALID,
  .ARREADY, .RVALID, .RREADY, .RDATA, .SYS_CLK_PLL_SEL, .SYS_CLK_OSC_SEL,
  .CPU_CLK_EN);
`default_nettype wire

// ===== verification/pmc_assertions.sv
// port checker for the pll and power mode controller
// assumes binding to the top module, one clock domain
`timescale 1ns/10ps
`default_nettype none
module pmc_assertions (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  input wire logic SYS_CLK_PLL_SEL,
  input wire logic SYS_CLK_OSC_SEL,
  input wire logic CPU_CLK_EN
);
  // ----------------------------------------
  // clock switch and bus relations
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);
  sequence gap_s;
    (!SYS_CLK_PLL_SEL && !SYS_CLK_OSC_SEL) [*3];
  endsequence
  sel_excl_a: assert property (!(SYS_CLK_PLL_SEL && SYS_CLK_OSC_SEL))
    else $error("both clock selects high");
  osc_to_pll_a: assert property (
    $fell(SYS_CLK_OSC_SEL) |-> gap_s ##1 SYS_CLK_PLL_SEL)
    else $error("bad switch to pll");
  pll_to_osc_a: assert property (
    $fell(SYS_CLK_PLL_SEL) |-> gap_s ##1 SYS_CLK_OSC_SEL)
    else $error("bad switch to oscillator");
  // both taken at one edge: write lands next edge, answer seen after
  wr_answer_a: assert property (
    AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write answer late");
  rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read answer late");
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  busy_refuse_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while busy");
  cpu_stop_a: assert property ($fell(CPU_CLK_EN) |-> $rose(BVALID))
    else $error("cpu clock stopped without write");
endmodule
`default_nettype wire

// ===== verification/wake_source.sv
// model of the wake pin and rtc alarm sources
// assumes level requests from the bench on clk
`timescale 1ns/10ps
`default_nettype none
module wake_source (
  input wire logic clk,
  input wire logic pol,
  input wire logic slow,
  input wire logic pin_req,
  input wire logic rtc_req,
  input wire logic irq_req,
  output logic wake_pin,
  output logic rtc_alarm,
  output logic ext_irq
);
  // ----------------------------------------
  // delayed events, slow answers three cycles late
  // ----------------------------------------
  logic [2:0] pin_reg = 3'h0;
  logic [2:0] rtc_reg = 3'h0;
  always @(posedge clk) pin_reg <= {pin_reg[1:0], pin_req};
  always @(posedge clk) rtc_reg <= {rtc_reg[1:0], rtc_req};
  assign wake_pin = pol ^ (slow ? pin_reg[2] : pin_reg[0]);
  assign rtc_alarm = slow ? rtc_reg[2] : rtc_reg[0];
  assign ext_irq = irq_req;
endmodule
`default_nettype wire

// ===== verilog/pll_and_power_mode_control.sv
// pll divider settings, clock source switch and power modes
// assumes axi4-lite master, inputs synchronous to REF_CLK
// Notes on behaviour
// - each pll output is reference times feedback over both dividers
// - reference divider is the six-bit field plus one
// - feedback factor is the twelve-bit field plus one
// - post-vco divider is the three-bit field plus one
// - each pll powers down by its config bit; lock reported after
// - five modes: normal, slow, idle, stop, power-off
// - normal mode runs all; gating register stops chosen unit clocks
// - source field 11 moves system clock to the oscillator
// - magic word to cpu power-down stops cpu until irq or wake
// - mode field 100 makes power-down halt all unit clocks
// - wake pin or rtc alarm ends stop; enables and polarity chosen
// - pin wake ending stop sets pending interrupt; bit 3 write clears it
// - power-off handled by rtc; alarm raises supply wake request
// - bit 6 polarity, bit 5 rtc disable, bit 4 pin disable
// - status bits 0 to 2 show each pll locked
// - upper half of power control holds lock period, reset 0x0bb8
`timescale 1ns/10ps
`default_nettype none
module pll_and_power_mode_control
  import pmc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic EXT_IRQ,
  input wire logic WAKE_PIN,
  input wire logic RTC_ALARM,
  output logic [20:0] PLL_REF_DIVIDER,
  output logic [38:0] PLL_FEEDBACK_FACTOR,
  output logic [11:0] PLL_POST_VCO_DIVIDER,
  output logic [2:0] PLL_BYPASS,
  output logic [2:0] PLL_POWER_DOWN,
  output logic SYS_CLK_PLL_SEL,
  output logic SYS_CLK_OSC_SEL,
  output logic CPU_CLK_EN,
  output logic [26:0] UNIT_CLK_EN,
  output logic CTRL_IRQ,
  output logic SUPPLY_WAKE
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == OFF_PLLCON0 || a == OFF_PLLCON1 || a == OFF_PLLCON2 ||
           a == OFF_DIVCON || a == OFF_CLKCFG || a == OFF_PWRCTL ||
           a == OFF_CPUPD || a == OFF_STATUS;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [22:0] pll_cfg_reg [NUM_PLL];
  logic [1:0] divcon_reg;
  logic [26:0] clkcfg_reg;
  logic [15:0] lock_period_reg;
  logic pol_reg;
  logic dis_rtc_reg;
  logic dis_pin_reg;
  logic [2:0] mode_reg;
  logic irq_pending_reg;
  logic [31:0] cpupd_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0] wr_strb_reg;
  logic [1:0] gap_reg;
  power_state_t state_reg;
  power_state_t state_next;
  logic [2:0] locked;
  logic [2:0] pll_restart;
  logic [2:0] pll_pd;
  logic do_write;
  logic [31:0] wr_merged;
  logic [31:0] rd_value;
  logic cpupd_hit;
  logic pin_active;
  logic pin_wake;
  logic rtc_wake;
  logic all_ready;
  logic want_osc;

  assign do_write = !AWREADY && !WREADY && !BVALID;
  assign pin_active = WAKE_PIN ^ pol_reg;
  assign pin_wake = pin_active && !dis_pin_reg;
  assign rtc_wake = RTC_ALARM && !dis_rtc_reg;
  assign want_osc = divcon_reg == CLKSRC_OSC;

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 32'h00000000;
      wr_strb_reg <= 4'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        AWREADY <= 1'b0;
        wr_addr_reg <= AWADDR;
      end
      if (WVALID && WREADY) begin
        WREADY <= 1'b0;
        wr_data_reg <= WDATA;
        wr_strb_reg <= WSTRB;
      end
      if (do_write) begin
        BVALID <= 1'b1;
        BRESP <= mapped(wr_addr_reg) ? RESP_OKAY : RESP_DECERR;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // own old value per register, so a read in flight never leaks in
  // clear bit merges as zero: a write without byte 0 never clears
  always_comb begin
    case (wr_addr_reg)
      OFF_PLLCON0: wr_merged = merge({9'h000, pll_cfg_reg[0]},
                                     wr_data_reg, wr_strb_reg);
      OFF_PLLCON1: wr_merged = merge({9'h000, pll_cfg_reg[1]},
                                     wr_data_reg, wr_strb_reg);
      OFF_PLLCON2: wr_merged = merge({9'h000, pll_cfg_reg[2]},
                                     wr_data_reg, wr_strb_reg);
      OFF_DIVCON: wr_merged = merge({30'h00000000, divcon_reg},
                                    wr_data_reg, wr_strb_reg);
      OFF_CLKCFG: wr_merged = merge({5'h00, clkcfg_reg}, wr_data_reg,
                                    wr_strb_reg);
      OFF_PWRCTL: wr_merged = merge({lock_period_reg, 9'h000, pol_reg,
                                     dis_rtc_reg, dis_pin_reg, 1'b0,
                                     mode_reg}, wr_data_reg, wr_strb_reg);
      OFF_CPUPD: wr_merged = merge(cpupd_reg, wr_data_reg, wr_strb_reg);
      default: wr_merged = merge(32'h00000000, wr_data_reg, wr_strb_reg);
    endcase
  end

  assign cpupd_hit = do_write && wr_addr_reg == OFF_CPUPD &&
                     wr_merged == CPUPD_MAGIC;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < NUM_PLL; i++) begin
        pll_cfg_reg[i] <= PLLCFG_RESET;
      end
      pll_restart <= 3'b000;
    end else begin
      pll_restart <= 3'b000;
      for (int i = 0; i < NUM_PLL; i++) begin
        if (do_write && wr_addr_reg == OFF_PLLCON0 + 8'(4 * i)) begin
          pll_cfg_reg[i] <= wr_merged[PLLCFG_W-1:0];
          pll_restart[i] <= wr_merged[OD_LSB+OD_W-1:0] !=
                            pll_cfg_reg[i][OD_LSB+OD_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      divcon_reg <= DIVCON_RESET;
      clkcfg_reg <= CLKCFG_RESET;
      cpupd_reg <= CPUPD_RESET;
    end else if (do_write) begin
      if (wr_addr_reg == OFF_DIVCON) begin
        divcon_reg <= wr_merged[1:0];
      end
      if (wr_addr_reg == OFF_CLKCFG) begin
        clkcfg_reg <= wr_merged[UNIT_W-1:0];
      end
      if (wr_addr_reg == OFF_CPUPD) begin
        cpupd_reg <= wr_merged;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      lock_period_reg <= LOCK_PERIOD_RESET;
      pol_reg <= 1'b0;
      dis_rtc_reg <= 1'b0;
      dis_pin_reg <= 1'b0;
      mode_reg <= MODE_NORMAL;
    end else if (do_write && wr_addr_reg == OFF_PWRCTL) begin
      lock_period_reg <= wr_merged[LOCK_LSB +: 16];
      pol_reg <= wr_merged[POL_BIT];
      dis_rtc_reg <= wr_merged[DIS_RTC_BIT];
      dis_pin_reg <= wr_merged[DIS_PIN_BIT];
      mode_reg <= wr_merged[2:0];
    end
  end

  // pending wake interrupt, a new set beats a clear
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      irq_pending_reg <= 1'b0;
    end else if (state_reg == ST_STOP && pin_wake) begin
      irq_pending_reg <= 1'b1;
    end else if (do_write && wr_addr_reg == OFF_PWRCTL &&
                 wr_merged[IRQCLR_BIT]) begin
      irq_pending_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  always_comb begin
    rd_value = 32'h00000000;
    case (ARADDR)
      OFF_PLLCON0: rd_value = {9'h000, pll_cfg_reg[0]};
      OFF_PLLCON1: rd_value = {9'h000, pll_cfg_reg[1]};
      OFF_PLLCON2: rd_value = {9'h000, pll_cfg_reg[2]};
      OFF_DIVCON: rd_value = {30'h00000000, divcon_reg};
      OFF_CLKCFG: rd_value = {5'h00, clkcfg_reg};
      OFF_PWRCTL: rd_value = {lock_period_reg, 9'h000, pol_reg,
                              dis_rtc_reg, dis_pin_reg, irq_pending_reg,
                              mode_reg};
      OFF_CPUPD: rd_value = cpupd_reg;
      OFF_STATUS: rd_value = {27'h0000000, SYS_CLK_PLL_SEL ||
                              SYS_CLK_OSC_SEL, SYS_CLK_PLL_SEL ||
                              SYS_CLK_OSC_SEL, locked};
      default: rd_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_value;
      RRESP <= mapped(ARADDR) ? RESP_OKAY : RESP_DECERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // ----------------------------------------
  // pll factors and lock
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      PLL_REF_DIVIDER <= 21'h000000;
      PLL_FEEDBACK_FACTOR <= 39'h0000000000;
      PLL_POST_VCO_DIVIDER <= 12'h000;
      PLL_BYPASS <= 3'b000;
      PLL_POWER_DOWN <= 3'b111;
    end else begin
      for (int i = 0; i < NUM_PLL; i++) begin
        PLL_REF_DIVIDER[i*7 +: 7] <=
          {1'b0, pll_cfg_reg[i][REF_LSB +: REF_W]} + 7'h01;
        PLL_FEEDBACK_FACTOR[i*13 +: 13] <=
          {1'b0, pll_cfg_reg[i][FB_LSB +: FB_W]} + 13'h0001;
        PLL_POST_VCO_DIVIDER[i*4 +: 4] <=
          {1'b0, pll_cfg_reg[i][OD_LSB +: OD_W]} + 4'h1;
        PLL_BYPASS[i] <= pll_cfg_reg[i][BYP_BIT];
      end
      PLL_POWER_DOWN <= pll_pd;
    end
  end

  for (genvar g = 0; g < NUM_PLL; g++) begin : gen_lock
    // stop mode forces every pll down
    assign pll_pd[g] = pll_cfg_reg[g][PDN_BIT] ||
                       state_reg == ST_STOP;
    pll_lock_timer u_lock (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .power_down(pll_pd[g]),
      .restart(pll_restart[g]),
      .period(lock_period_reg),
      .locked(locked[g])
    );
  end

  assign all_ready = &(locked | pll_pd);

  // ----------------------------------------
  // power mode sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (cpupd_hit) begin
          state_next = mode_reg == MODE_STOP ? ST_STOP : ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (EXT_IRQ || pin_wake) begin
          state_next = ST_RUN;
        end
      end
      ST_STOP: begin
        if (pin_wake || rtc_wake) begin
          state_next = ST_RELOCK;
        end
      end
      ST_RELOCK: begin
        if (all_ready) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      CPU_CLK_EN <= 1'b1;
      UNIT_CLK_EN <= {UNIT_W{1'b1}};
      CTRL_IRQ <= 1'b0;
      SUPPLY_WAKE <= 1'b0;
    end else begin
      CPU_CLK_EN <= state_next == ST_RUN;
      if (state_next == ST_RUN || state_next == ST_IDLE) begin
        UNIT_CLK_EN <= ~clkcfg_reg;
      end else begin
        UNIT_CLK_EN <= {UNIT_W{1'b0}};
      end
      CTRL_IRQ <= irq_pending_reg;
      SUPPLY_WAKE <= rtc_wake;
    end
  end

  // ----------------------------------------
  // glitch-free source switch
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      SYS_CLK_PLL_SEL <= 1'b0;
      SYS_CLK_OSC_SEL <= 1'b1;
      gap_reg <= 2'h0;
    end else if (SYS_CLK_PLL_SEL && want_osc) begin
      SYS_CLK_PLL_SEL <= 1'b0;
      gap_reg <= CLKSW_GAP;
    end else if (SYS_CLK_OSC_SEL && !want_osc) begin
      SYS_CLK_OSC_SEL <= 1'b0;
      gap_reg <= CLKSW_GAP;
    end else if (!SYS_CLK_PLL_SEL && !SYS_CLK_OSC_SEL) begin
      if (gap_reg != 2'h0) begin
        gap_reg <= gap_reg - 2'h1;
      end else if (want_osc) begin
        SYS_CLK_OSC_SEL <= 1'b1;
      end else begin
        SYS_CLK_PLL_SEL <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/pll_lock_timer.sv
// lock timer for one pll: counts the lock period after power-up
// assumes period in reference clock cycles; restart on factor change
`timescale 1ns/10ps
`default_nettype none
module pll_lock_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_down,
  input wire logic restart,
  input wire logic [15:0] period,
  output logic locked
);
  logic [15:0] count_reg;

  // ----------------------------------------
  // lock counter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst || power_down || restart) begin
      count_reg <= 16'h0000;
      locked <= 1'b0;
    end else if (!locked) begin
      if (count_reg >= period) begin
        locked <= 1'b1;
      end else begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/pmc_pkg.sv
// constants for the pll and power mode controller
// assumes a 32-bit axi4-lite register bus with 8-bit byte addresses
package pmc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_PLLCON0 = 8'h00;
  localparam logic [7:0] OFF_PLLCON1 = 8'h04;
  localparam logic [7:0] OFF_PLLCON2 = 8'h08;
  localparam logic [7:0] OFF_DIVCON = 8'h0c;
  localparam logic [7:0] OFF_CLKCFG = 8'h18;
  localparam logic [7:0] OFF_PWRCTL = 8'h20;
  localparam logic [7:0] OFF_CPUPD = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h2c;
  // ----------------------------------------
  // pll config fields
  // ----------------------------------------
  localparam int NUM_PLL = 3;
  localparam int REF_LSB = 0;
  localparam int REF_W = 6;
  localparam int FB_LSB = 6;
  localparam int FB_W = 12;
  localparam int OD_LSB = 18;
  localparam int OD_W = 3;
  localparam int BYP_BIT = 21;
  localparam int PDN_BIT = 22;
  localparam int PLLCFG_W = 23;
  localparam logic [22:0] PLLCFG_RESET = 23'h000000;
  // ----------------------------------------
  // clock source, gating, power control
  // ----------------------------------------
  localparam logic [1:0] CLKSRC_OSC = 2'b11;
  localparam logic [1:0] DIVCON_RESET = 2'b00;
  localparam int UNIT_W = 27;
  localparam logic [26:0] CLKCFG_RESET = 27'h0000000;
  localparam logic [2:0] MODE_NORMAL = 3'b000;
  localparam logic [2:0] MODE_STOP = 3'b100;
  localparam int IRQCLR_BIT = 3;
  localparam int DIS_PIN_BIT = 4;
  localparam int DIS_RTC_BIT = 5;
  localparam int POL_BIT = 6;
  localparam int LOCK_LSB = 16;
  localparam logic [15:0] LOCK_PERIOD_RESET = 16'h0bb8;
  localparam logic [31:0] CPUPD_MAGIC = 32'hdeedbabe;
  localparam logic [31:0] CPUPD_RESET = 32'h00000000;
  localparam logic [1:0] CLKSW_GAP = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_IDLE = 2'b01,
    ST_STOP = 2'b10,
    ST_RELOCK = 2'b11
  } power_state_t;
endpackage
